// ===== hdl/tsa_consts.svh
// constants for the tag state and anticollision link
`ifndef TSA_CONSTS_SVH
`define TSA_CONSTS_SVH
`define TSA_HANDLE_W 8
`define TSA_HANDLE_RST 8'h00
`define TSA_SLOT_W 4
`define TSA_CMD_W 4
`define TSA_SLOT_LAST 4'hf
`define TSA_SLOT_ZERO 4'h0
`define TSA_LFSR_SEED 16'hace1
`define TSA_LFSR_TAPS 16'hb400
`define TSA_ANS_WAIT 8'h10
`endif

// ===== hdl/tsa_pkg.sv
// types shared by the tag and reader ends
`include "tsa_consts.svh"
package tsa_pkg;
  typedef enum logic [3:0] {
    TSA_CMD_OPEN_INV  = 4'h0,
    TSA_CMD_SLOT_RND  = 4'h1,
    TSA_CMD_SLOT_ADV  = 4'h2,
    TSA_CMD_PICK      = 4'h3,
    TSA_CMD_FETCH_WD  = 4'h4,
    TSA_CMD_STORE_WD  = 4'h5,
    TSA_CMD_FETCH_SER = 4'h6,
    TSA_CMD_RETIRE    = 4'h7
  } tsa_cmd_e;
  typedef enum logic [2:0] {
    TSA_ST_READY = 3'h0,
    TSA_ST_INV   = 3'h1,
    TSA_ST_SEL   = 3'h2,
    TSA_ST_DESEL = 3'h3,
    TSA_ST_DEACT = 3'h4
  } tsa_state_e;
  typedef logic [7:0] tsa_handle_t;
  typedef logic [3:0] tsa_slot_t;
endpackage

// ===== hdl/tsa_link_if.sv
// link between the reader end and one tag end
`timescale 1ns/1ps
interface tsa_link_if;
  import tsa_pkg::*;
  logic cmd_valid; // one-cycle command strobe
  tsa_cmd_e cmd_code;
  tsa_handle_t cmd_arg; // handle or slot_param in low nibble
  logic field_on; // field strong enough
  logic ans_valid; // one-cycle answer strobe
  tsa_handle_t ans_data;
  logic exec_valid; // tag executed an access command
  modport tag (input cmd_valid, input cmd_code, input cmd_arg, input field_on,
    output ans_valid, output ans_data, output exec_valid);
  modport reader (output cmd_valid, output cmd_code, output cmd_arg, output field_on,
    input ans_valid, input ans_data, input exec_valid);
endinterface

// ===== hdl/tsa_rand.sv
// free-running random source for the tag
`timescale 1ns/1ps
`include "tsa_consts.svh"
module tsa_rand #(
  parameter logic [15:0] SEED = `TSA_LFSR_SEED
) (
  input wire logic clk,
  input wire logic sys_rst,
  output logic [15:0] rnd
);
  logic [15:0] lfsr_reg;
  // galois shift register advancing every cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lfsr_reg <= `TSA_LFSR_SEED;
    end else begin
      lfsr_reg <= (lfsr_reg >> 1) ^ (lfsr_reg[0] ? `TSA_LFSR_TAPS : 16'h0000);
    end
  end
  assign rnd = lfsr_reg ^ SEED ^ `TSA_LFSR_SEED;
endmodule

// ===== hdl/tsa_tag.sv
// tag end: command state machine and slotted anticollision
// Overview of operation
// - weak field forces power-off, return resets ready
// - ready state ignores all but open inventory
// - open inventory in ready enters inventory
// - inventory acts on anticollision commands, stays
// - matching pick in inventory selects the tag
// - selected executes accesses, ignores anticollision commands
// - non-matching pick in selected deselects
// - retire in selected deactivates the tag
// - deselected returns to selected only on match
// - deactivated ignores everything until field loss
// - eight-bit handle reloaded randomly on ready, open
// - low nibble of handle is slot code
// - slot round draws new code, answers on zero
// - slot advance answers only when slot matches
// - sixteen slots: round is zero, advance 1-15
// - open inventory answers immediately, no slot delay
// - at most one answer per slot round
// - ready tag silent to slot commands
// - reader opens inventory, repeats, selects or rounds
// - reader picks single answers, skips silence, collisions
// - reader serves single answers in their slots until a collision in the round; after slot 15 it starts a new round if one collided, else reopens inventory
`timescale 1ns/1ps
`include "tsa_consts.svh"
module tsa_tag #(
  parameter logic [15:0] SEED = `TSA_LFSR_SEED
) (
  input wire logic clk,
  input wire logic sys_rst,
  tsa_link_if.tag link,
  output tsa_pkg::tsa_state_e state,
  output tsa_pkg::tsa_handle_t handle,
  output logic answered_round
);
  import tsa_pkg::*;

  // ----------------------------------------
  // random source and handle matching
  // ----------------------------------------
  logic [15:0] rnd;
  logic rst_all;
  tsa_state_e state_reg;
  tsa_state_e state_next;
  tsa_handle_t handle_reg;
  logic answered_reg;
  logic ans_valid_reg;
  tsa_handle_t ans_data_reg;
  logic exec_reg;
  logic cmd_ok;
  logic slot_hit;
  logic open_take;
  logic slot_take;
  logic adv_answer;

  // field loss holds state, answers and flags in reset, not the handle or random source
  assign rst_all = sys_rst | ~link.field_on;

  tsa_rand #(.SEED(SEED)) u_rand (
    .clk(clk),
    .sys_rst(sys_rst),
    .rnd(rnd)
  );

  function automatic logic handle_match(input tsa_handle_t a, input tsa_handle_t b);
    handle_match = (a == b);
  endfunction

  assign cmd_ok = link.cmd_valid;

  // open inventory is taken from ready and from inventory
  assign open_take = cmd_ok && link.cmd_code == TSA_CMD_OPEN_INV &&
    (state_reg == TSA_ST_READY || state_reg == TSA_ST_INV);
  // slot commands only count inside inventory
  assign slot_take = cmd_ok && state_reg == TSA_ST_INV;

  // access commands: word fetch, word store, serial fetch
  function automatic logic is_access(input tsa_cmd_e c);
    is_access = c == TSA_CMD_FETCH_WD || c == TSA_CMD_STORE_WD || c == TSA_CMD_FETCH_SER;
  endfunction

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  // next state per current state and command
  always_comb begin
    state_next = state_reg;
    if (cmd_ok) begin
      unique case (state_reg)
        TSA_ST_READY: begin
          if (link.cmd_code == TSA_CMD_OPEN_INV) begin
            state_next = TSA_ST_INV;
          end
        end
        TSA_ST_INV: begin
          if (link.cmd_code == TSA_CMD_PICK && handle_match(link.cmd_arg, handle_reg)) begin
            state_next = TSA_ST_SEL;
          end
        end
        TSA_ST_SEL: begin
          if (link.cmd_code == TSA_CMD_PICK && !handle_match(link.cmd_arg, handle_reg)) begin
            state_next = TSA_ST_DESEL;
          end else if (link.cmd_code == TSA_CMD_RETIRE) begin
            state_next = TSA_ST_DEACT;
          end
        end
        TSA_ST_DESEL: begin
          if (link.cmd_code == TSA_CMD_PICK && handle_match(link.cmd_arg, handle_reg)) begin
            state_next = TSA_ST_SEL;
          end
        end
        TSA_ST_DEACT: begin
          state_next = TSA_ST_DEACT;
        end
        default: begin
          state_next = TSA_ST_READY;
        end
      endcase
    end
  end

  // state register, reset by field loss into ready
  always_ff @(posedge clk or posedge rst_all) begin
    if (rst_all) begin
      state_reg <= TSA_ST_READY;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // handle and slot code
  // ----------------------------------------
  // reload every idle cycle in ready or without field, on open inventory, slot round
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      handle_reg <= `TSA_HANDLE_RST;
    end else if (!link.field_on || state_reg == TSA_ST_READY && !cmd_ok) begin
      handle_reg <= rnd[7:0];
    end else if (open_take) begin
      handle_reg <= rnd[7:0];
    end else if (slot_take && link.cmd_code == TSA_CMD_SLOT_RND) begin
      handle_reg <= {handle_reg[7:4], rnd[11:8]};
    end
  end

  // slot advance compares the low nibble only
  assign slot_hit = link.cmd_arg[3:0] == handle_reg[3:0];
  // an advance answers on its own slot, once per round, never slot zero
  assign adv_answer = slot_hit && !answered_reg && link.cmd_arg[3:0] != `TSA_SLOT_ZERO;

  // ----------------------------------------
  // answers
  // ----------------------------------------
  // answer strobe one cycle after the command
  always_ff @(posedge clk or posedge rst_all) begin
    if (rst_all) begin
      ans_valid_reg <= 1'b0;
      ans_data_reg <= `TSA_HANDLE_RST;
    end else begin
      ans_valid_reg <= 1'b0;
      if (open_take) begin
        ans_valid_reg <= 1'b1;
        ans_data_reg <= rnd[7:0];
      end else if (slot_take) begin
        unique case (link.cmd_code)
          TSA_CMD_SLOT_RND: begin
            ans_valid_reg <= (rnd[11:8] == `TSA_SLOT_ZERO);
            ans_data_reg <= {handle_reg[7:4], rnd[11:8]};
          end
          TSA_CMD_SLOT_ADV: begin
            if (adv_answer) begin
              ans_valid_reg <= 1'b1;
              ans_data_reg <= handle_reg;
            end
          end
          default: begin
            ans_valid_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // answered flag: set by a slot answer, cleared by open inventory
  always_ff @(posedge clk or posedge rst_all) begin
    if (rst_all) begin
      answered_reg <= 1'b0;
    end else if (open_take) begin
      answered_reg <= 1'b0;
    end else if (slot_take && link.cmd_code == TSA_CMD_SLOT_RND) begin
      answered_reg <= (rnd[11:8] == `TSA_SLOT_ZERO);
    end else if (slot_take && link.cmd_code == TSA_CMD_SLOT_ADV && adv_answer) begin
      answered_reg <= 1'b1;
    end
  end

  // access commands run only while selected
  always_ff @(posedge clk or posedge rst_all) begin
    if (rst_all) begin
      exec_reg <= 1'b0;
    end else begin
      exec_reg <= cmd_ok && state_reg == TSA_ST_SEL && is_access(link.cmd_code);
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // link strobes and status straight from flip-flops
  assign link.ans_valid = ans_valid_reg;
  assign link.ans_data = ans_data_reg;
  assign link.exec_valid = exec_reg;
  assign state = state_reg;
  assign handle = handle_reg;
  assign answered_round = answered_reg;
endmodule

// ===== hdl/tsa_reader.sv
// reader end: anticollision procedure driving the link
`timescale 1ns/1ps
`include "tsa_consts.svh"
module tsa_reader (
  input wire logic clk,
  input wire logic sys_rst,
  tsa_link_if.reader link,
  input wire logic run,
  input wire logic ans_collide,
  output tsa_pkg::tsa_handle_t found_handle,
  output logic found_valid,
  output logic busy
);
  import tsa_pkg::*;

  typedef enum logic [2:0] {
    TSA_RD_IDLE = 3'h0,
    TSA_RD_OPEN = 3'h1,
    TSA_RD_WAIT = 3'h2,
    TSA_RD_PICK = 3'h3,
    TSA_RD_ACC  = 3'h4,
    TSA_RD_DROP = 3'h5,
    TSA_RD_SLOT = 3'h6
  } tsa_rd_e;

  // ----------------------------------------
  // sequencer state
  // ----------------------------------------
  tsa_rd_e st_reg;
  logic [7:0] wait_reg;
  tsa_slot_t slot_reg;
  logic in_round_reg;
  logic coll_reg;
  logic got_reg;
  tsa_handle_t id_reg;
  logic cmd_v_reg;
  tsa_cmd_e cmd_c_reg;
  tsa_handle_t cmd_a_reg;
  logic found_reg;

  // issues commands and collects answers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= TSA_RD_IDLE;
      wait_reg <= 8'h00;
      slot_reg <= 4'h0;
      in_round_reg <= 1'b0;
      coll_reg <= 1'b0;
      got_reg <= 1'b0;
      id_reg <= 8'h00;
      cmd_v_reg <= 1'b0;
      cmd_c_reg <= TSA_CMD_OPEN_INV;
      cmd_a_reg <= 8'h00;
      found_reg <= 1'b0;
    end else begin
      cmd_v_reg <= 1'b0;
      found_reg <= 1'b0;
      unique case (st_reg)
        TSA_RD_IDLE: begin
          if (run) begin
            st_reg <= TSA_RD_OPEN;
          end
        end
        TSA_RD_OPEN: begin
          cmd_v_reg <= 1'b1;
          cmd_c_reg <= in_round_reg ? (slot_reg == `TSA_SLOT_ZERO ? TSA_CMD_SLOT_RND : TSA_CMD_SLOT_ADV)
            : TSA_CMD_OPEN_INV;
          cmd_a_reg <= {4'h0, slot_reg};
          if (in_round_reg && slot_reg == `TSA_SLOT_ZERO) begin
            coll_reg <= 1'b0;
          end
          got_reg <= 1'b0;
          wait_reg <= `TSA_ANS_WAIT;
          st_reg <= TSA_RD_WAIT;
        end
        TSA_RD_WAIT: begin
          if (link.ans_valid) begin
            got_reg <= 1'b1;
            id_reg <= link.ans_data;
            if (ans_collide) begin
              coll_reg <= 1'b1;
            end
          end
          wait_reg <= wait_reg - 8'h01;
          if (wait_reg == 8'h00) begin
            if (got_reg && !coll_reg) begin
              st_reg <= TSA_RD_PICK;
            end else if (!in_round_reg && coll_reg) begin
              in_round_reg <= 1'b1;
              slot_reg <= `TSA_SLOT_ZERO;
              st_reg <= TSA_RD_OPEN;
            end else begin
              st_reg <= TSA_RD_SLOT;
            end
          end
        end
        TSA_RD_PICK: begin
          cmd_v_reg <= 1'b1;
          cmd_c_reg <= TSA_CMD_PICK;
          cmd_a_reg <= id_reg;
          found_reg <= 1'b1;
          st_reg <= TSA_RD_ACC;
        end
        TSA_RD_ACC: begin
          cmd_v_reg <= 1'b1;
          cmd_c_reg <= TSA_CMD_FETCH_SER;
          st_reg <= TSA_RD_DROP;
        end
        TSA_RD_DROP: begin
          cmd_v_reg <= 1'b1;
          cmd_c_reg <= TSA_CMD_RETIRE;
          st_reg <= TSA_RD_SLOT;
        end
        TSA_RD_SLOT: begin
          if (!in_round_reg || slot_reg == `TSA_SLOT_LAST) begin
            in_round_reg <= in_round_reg && slot_reg == `TSA_SLOT_LAST && coll_reg;
            slot_reg <= `TSA_SLOT_ZERO;
            st_reg <= run ? TSA_RD_OPEN : TSA_RD_IDLE;
          end else begin
            slot_reg <= slot_reg + 4'h1;
            st_reg <= TSA_RD_OPEN;
          end
        end
        default: begin
          st_reg <= TSA_RD_IDLE;
        end
      endcase
    end
  end

  assign link.cmd_valid = cmd_v_reg;
  assign link.cmd_code = cmd_c_reg;
  assign link.cmd_arg = cmd_a_reg;
  assign link.field_on = ~sys_rst;
  assign found_handle = id_reg;
  assign found_valid = found_reg;
  assign busy = st_reg != TSA_RD_IDLE;
endmodule

// ===== verification/tsa_link_checker.sv
// assertions on the link between reader end and tag end
`timescale 1ns/1ps
module tsa_link_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire tsa_pkg::tsa_cmd_e cmd_code,
  input wire tsa_pkg::tsa_handle_t cmd_arg,
  input wire logic ans_valid,
  input wire tsa_pkg::tsa_handle_t ans_data,
  input wire logic exec_valid
);
  import tsa_pkg::*;
  logic seen_reg;
  logic got_reg;
  tsa_slot_t slot_reg;
  // --------------------------
  // helper state
  // --------------------------
  // first command seen since reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) seen_reg <= 1'b0;
    else if (cmd_valid) seen_reg <= 1'b1;
  end
  // a slot answer already came in this round
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) got_reg <= 1'b0;
    else if (cmd_valid && cmd_code inside {TSA_CMD_OPEN_INV, TSA_CMD_SLOT_RND}) got_reg <= 1'b0;
    else if (ans_valid && $past(cmd_code) != TSA_CMD_OPEN_INV) got_reg <= 1'b1;
  end
  // slot number the next slot advance must carry
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) slot_reg <= 4'h0;
    else if (cmd_valid && cmd_code == TSA_CMD_SLOT_RND) slot_reg <= 4'h1;
    else if (cmd_valid && cmd_code == TSA_CMD_SLOT_ADV) slot_reg <= slot_reg + 4'h1;
  end
  // --------------------------
  // assertions
  // --------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_ans_has_cause: assert property (ans_valid |-> $past(cmd_valid) &&
    $past(cmd_code) inside {TSA_CMD_OPEN_INV, TSA_CMD_SLOT_RND, TSA_CMD_SLOT_ADV})
    else $error("answer without anticollision command");
  a_exec_has_cause: assert property (exec_valid |-> $past(cmd_valid) &&
    $past(cmd_code) inside {TSA_CMD_FETCH_WD, TSA_CMD_STORE_WD, TSA_CMD_FETCH_SER})
    else $error("access without access command");
  a_round_zero: assert property (
    ans_valid && $past(cmd_code) == TSA_CMD_SLOT_RND |-> ans_data[3:0] == 4'h0)
    else $error("slot zero answer with nonzero code");
  a_adv_match: assert property (
    ans_valid && $past(cmd_code) == TSA_CMD_SLOT_ADV |-> ans_data[3:0] == $past(cmd_arg[3:0]))
    else $error("slot answer code differs from slot");
  a_one_per_round: assert property (
    ans_valid && $past(cmd_code) == TSA_CMD_SLOT_ADV |-> !got_reg)
    else $error("second answer in one round");
  a_adv_in_order: assert property (
    cmd_valid && cmd_code == TSA_CMD_SLOT_ADV |-> cmd_arg[3:0] == slot_reg && slot_reg != 4'h0)
    else $error("slot advance out of order");
  a_first_open: assert property (cmd_valid && !seen_reg |-> cmd_code == TSA_CMD_OPEN_INV)
    else $error("first command is not open inventory");
  a_open_answers: assert property (cmd_valid && !seen_reg |=> ans_valid)
    else $error("no answer to first open inventory");
endmodule

// ===== verification/tb.sv
// self-checking bench: reader with tag, plus a bench-driven tag
`timescale 1ns/1ps
module tb;
  import tsa_pkg::*;
  typedef struct packed {
    tsa_cmd_e code;
    logic [1:0] mode;
    logic ans;
    logic exe;
    tsa_state_e st;
  } tsa_row_s;
  logic clk, sys_rst, run, ans_collide, found_valid, busy, ar_a, ar_b, got_ans, got_exe;
  tsa_handle_t got_dat, found_handle, hd_a, hd_b;
  tsa_state_e st_a, st_b;
  tsa_slot_t n;
  int err_total = 0;
  int checked = 0;
  int hits;
  // command, argument kind (own handle / top bit flipped), answer, access, state after
  tsa_row_s rows [19] = '{
    '{TSA_CMD_FETCH_SER, 0, 0, 0, TSA_ST_READY},
    '{TSA_CMD_SLOT_RND, 0, 0, 0, TSA_ST_READY},
    '{TSA_CMD_PICK, 1, 0, 0, TSA_ST_READY},
    '{TSA_CMD_OPEN_INV, 0, 1, 0, TSA_ST_INV},
    '{TSA_CMD_OPEN_INV, 0, 1, 0, TSA_ST_INV},
    '{TSA_CMD_FETCH_WD, 0, 0, 0, TSA_ST_INV},
    '{TSA_CMD_PICK, 2, 0, 0, TSA_ST_INV},
    '{TSA_CMD_PICK, 1, 0, 0, TSA_ST_SEL},
    '{TSA_CMD_SLOT_RND, 0, 0, 0, TSA_ST_SEL},
    '{TSA_CMD_OPEN_INV, 0, 0, 0, TSA_ST_SEL},
    '{TSA_CMD_FETCH_WD, 0, 0, 1, TSA_ST_SEL},
    '{TSA_CMD_STORE_WD, 0, 0, 1, TSA_ST_SEL},
    '{TSA_CMD_FETCH_SER, 0, 0, 1, TSA_ST_SEL},
    '{TSA_CMD_PICK, 2, 0, 0, TSA_ST_DESEL},
    '{TSA_CMD_FETCH_SER, 0, 0, 0, TSA_ST_DESEL},
    '{TSA_CMD_PICK, 1, 0, 0, TSA_ST_SEL},
    '{TSA_CMD_RETIRE, 0, 0, 0, TSA_ST_DEACT},
    '{TSA_CMD_PICK, 1, 0, 0, TSA_ST_DEACT},
    '{TSA_CMD_OPEN_INV, 0, 0, 0, TSA_ST_DEACT}
  };
  tsa_link_if link_a ();
  tsa_link_if link_b ();
  tsa_reader tsa_reader_inst (.clk(clk), .sys_rst(sys_rst), .link(link_a), .run(run), .ans_collide(ans_collide),
    .found_handle(found_handle), .found_valid(found_valid), .busy(busy));
  tsa_tag tsa_tag_inst (.clk(clk), .sys_rst(sys_rst), .link(link_a), .state(st_a), .handle(hd_a),
    .answered_round(ar_a));
  tsa_tag tsa_tag2_inst (.clk(clk), .sys_rst(sys_rst), .link(link_b), .state(st_b), .handle(hd_b),
    .answered_round(ar_b));
  tsa_link_checker tsa_link_checker_inst (.clk(clk), .sys_rst(sys_rst), .cmd_valid(link_a.cmd_valid),
    .cmd_code(link_a.cmd_code), .cmd_arg(link_a.cmd_arg), .ans_valid(link_a.ans_valid),
    .ans_data(link_a.ans_data), .exec_valid(link_a.exec_valid));
  // --------------------------
  // shared tasks
  // --------------------------
  // one command on the bench link, answer sampled in its single cycle
  task automatic send(input tsa_cmd_e c, input tsa_handle_t a);
    link_b.cmd_valid = 1'b1;
    link_b.cmd_code = c;
    link_b.cmd_arg = a;
    @(negedge clk);
    got_ans = link_b.ans_valid;
    got_exe = link_b.exec_valid;
    got_dat = link_b.ans_data;
    link_b.cmd_valid = 1'b0;
    @(negedge clk);
  endtask
  // count a comparison, report a mismatch
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  // verdict and end of run
  task automatic end_of_test();
    if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // clock of 25 ns
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // watchdog on a hang
  initial begin
    #500000;
    err_total++;
    end_of_test();
  end
  // --------------------------
  // main sequence
  // --------------------------
  initial begin
    sys_rst = 1'b1;
    run = 1'b0;
    ans_collide = 1'b0;
    link_b.cmd_valid = 1'b0;
    link_b.cmd_code = TSA_CMD_OPEN_INV;
    link_b.cmd_arg = 8'h00;
    link_b.field_on = 1'b1;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    foreach (rows[i]) begin
      send(rows[i].code, rows[i].mode == 2'h1 ? hd_b : rows[i].mode == 2'h2 ? hd_b ^ 8'h80 : 8'h00);
      chk(got_ans === rows[i].ans && got_exe === rows[i].exe && st_b === rows[i].st, "row");
      if (got_ans === 1'b1) chk(got_dat === hd_b, "answer is not handle");
    end
    link_b.field_on = 1'b0;
    send(TSA_CMD_OPEN_INV, 8'h00);
    chk(got_ans === 1'b0 && st_b === TSA_ST_READY, "field loss");
    link_b.field_on = 1'b1;
    send(TSA_CMD_OPEN_INV, 8'h00);
    for (int r = 0; r < 24; r++) begin
      send(TSA_CMD_SLOT_RND, 8'h00);
      n = hd_b[3:0];
      hits = int'(got_ans);
      chk(got_ans === (n == 4'h0) && ar_b === (n == 4'h0), "slot zero");
      for (int k = 1; k < 16; k++) begin
        send(TSA_CMD_SLOT_ADV, 8'(k));
        hits += int'(got_ans);
        chk(got_ans === (n == k[3:0]) && (!got_ans || got_dat === hd_b), "slot answer");
      end
      chk(hits == 1 && st_b === TSA_ST_INV && ar_b === 1'b1, "answers per round");
    end
    run = 1'b1;
    for (int w = 0; w < 3000 && found_valid !== 1'b1; w++) @(negedge clk);
    chk(found_valid === 1'b1 && found_handle === hd_a && busy === 1'b1, "single answer found");
    for (int w = 0; w < 500 && st_a !== TSA_ST_DEACT; w++) @(negedge clk);
    chk(st_a === TSA_ST_DEACT, "tag not retired");
    sys_rst = 1'b1;
    ans_collide = 1'b1;
    repeat (10) @(negedge clk);
    chk(busy === 1'b0 && st_a === TSA_ST_READY && ar_a === 1'b0 && link_a.ans_valid === 1'b0, "reset state");
    sys_rst = 1'b0;
    for (int w = 0; w < 500 && !(link_a.cmd_valid === 1'b1 && link_a.cmd_code === TSA_CMD_SLOT_RND); w++)
      @(negedge clk);
    chk(link_a.cmd_code === TSA_CMD_SLOT_RND, "no round on collision");
    ans_collide = 1'b0;
    for (int w = 0; w < 3000 && found_valid !== 1'b1; w++) @(negedge clk);
    chk(found_valid === 1'b1 && found_handle === hd_a, "slot answer found");
    end_of_test();
  end
endmodule
